// ==== hw/ihpc_pkg.sv ====
package ihpc_pkg;
	// Command window offsets on the four low address lines.
	localparam logic [3:0] CMD_START = 4'h0;
	localparam logic [3:0] CMD_DIR = 4'h1;
	localparam logic [3:0] CMD_ABORT = 4'h2;
	localparam logic [3:0] RD_STATUS = 4'h0;
	localparam logic [3:0] RD_COLS = 4'h1;
	// Status byte bit positions.
	localparam int ST_BUSY = 0;
	localparam int ST_FIFO_EMPTY = 1;
	localparam int ST_DIR = 2;
	localparam int ST_DMA_REQ = 3;
	// Reset values.
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [23:0] RST_COL = 24'h000000;
	// Geometry.
	localparam int NOZZLES = 24;
	localparam int BYTES_PER_COL = 3;
	localparam int FIFO_DEPTH = 16;
	localparam logic [23:0] ODD_MASK = 24'h555555;
	localparam logic [23:0] EVEN_MASK = 24'hAAAAAA;
	// Pulse times in ns, and the reference crystal period in ns.
	localparam int T_DIS_NS = 62000;
	localparam int T_IDLE_NS = 8000;
	localparam int T_CHG_NS = 47500;
	localparam int REF_PERIOD_NS = 500;
	// Pulse lengths in reference ticks (rounded down, with no lower bound).
	localparam logic [7:0] DIS_TICKS = 8'(T_DIS_NS / REF_PERIOD_NS);
	localparam logic [7:0] IDLE_TICKS = 8'(T_IDLE_NS / REF_PERIOD_NS);
	localparam logic [7:0] CHG_TICKS = 8'(T_CHG_NS / REF_PERIOD_NS);
	// Pulse sequencer states.
	typedef enum logic [3:0] {
		PS_IDLE = 4'b0001,
		PS_DIS = 4'b0010,
		PS_GAP = 4'b0100,
		PS_CHG = 4'b1000
	} ihpc_pstate_e;
endpackage

// ==== hw/ihpc_head_ctrl.sv ====
// Summary of operation
// - Commands and reads take effect only while the peripheral select is high.
// - Low address lines decode commands; the block then runs the head alone.
// - Image bytes are requested by transfer request and taken without processor help.
// - Column bits are reordered for print direction and odd/even nozzle lines.
// - Each column is held in 24 latches, one per nozzle output.
// - Odd and even lines get their own pulses, each started by the strobe.
// - All pulse timing is counted in reference crystal ticks.
// - Printed nozzles fire high for about 62 us from the strobe; others stay low.
// - An 8 us idle follows the discharge, making a 70 us applied period.
// - Each line has an active-high refill pulse of about 47.5 us.
`timescale 1ns/10ps
`default_nettype none

// Synchronous FIFO with valid/ready on both sides.
module ihpc_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// Full and empty come straight from the occupancy count.
	assign in_ready = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data = mem[rd_ptr_r];

	// Storage has no reset; only pointers and count are control state.
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	// Pointer and count update; flush empties the queue on abort.
	always_ff @(posedge core_clk) begin
		if (rst || flush) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			wr_ptr_r <= push ? wr_ptr_r + 1'b1 : wr_ptr_r;
			rd_ptr_r <= pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// One nozzle line: discharge, idle gap, then refill, in reference ticks.
module ihpc_line_seq (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic trigger,
	input wire logic ref_tick,
	output logic fire_r,
	output logic refill_r,
	output logic busy
);
	ihpc_pkg::ihpc_pstate_e state_r;
	ihpc_pkg::ihpc_pstate_e state_nxt;
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	wire last_tick = ref_tick && (cnt_r == 8'h01);

	assign busy = (state_r != ihpc_pkg::PS_IDLE);

	// Next state: each phase lasts its tick count, refill strictly last.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = ref_tick ? cnt_r - 8'h01 : cnt_r;
		unique case (state_r)
			ihpc_pkg::PS_IDLE: begin
				cnt_nxt = ihpc_pkg::DIS_TICKS;
				if (trigger) begin
					state_nxt = ihpc_pkg::PS_DIS;
				end
			end
			ihpc_pkg::PS_DIS: begin
				if (last_tick) begin
					state_nxt = ihpc_pkg::PS_GAP;
					cnt_nxt = ihpc_pkg::IDLE_TICKS;
				end
			end
			ihpc_pkg::PS_GAP: begin
				if (last_tick) begin
					state_nxt = ihpc_pkg::PS_CHG;
					cnt_nxt = ihpc_pkg::CHG_TICKS;
				end
			end
			ihpc_pkg::PS_CHG: begin
				if (last_tick) begin
					state_nxt = ihpc_pkg::PS_IDLE;
				end
			end
		endcase
	end

	// Fire and refill outputs are registered so the head drivers see clean edges; busy is not.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_r <= ihpc_pkg::PS_IDLE;
			cnt_r <= ihpc_pkg::RST_BYTE;
			fire_r <= 1'b0;
			refill_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			fire_r <= (state_nxt == ihpc_pkg::PS_DIS);
			refill_r <= (state_nxt == ihpc_pkg::PS_CHG);
		end
	end
endmodule

// Head pulse controller top.
module ihpc_head_ctrl (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic peripheral_select_strobe,
	input wire logic [3:0] cmd_addr,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic [7:0] cmd_wdata,
	output logic [7:0] cmd_rdata,
	output logic transfer_request,
	input wire logic dma_ack,
	input wire logic [7:0] dma_data,
	input wire logic print_timing_strobe,
	input wire logic pulse_reference_crystal,
	output logic [23:0] nozzle_fire_output,
	output logic refill_pulse_first_line,
	output logic refill_pulse_second_line
);
	logic [7:0] cols_left_r;
	logic [9:0] bytes_left_r;
	logic dir_r;
	logic [1:0] byte_idx_r;
	logic [15:0] asm_r;
	logic [23:0] col_latch_r;
	logic [23:0] even_hold_r;
	logic ref_d_r;
	logic pts_d_r;
	logic fire_odd;
	logic fire_even;
	logic busy_odd;
	logic busy_even;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [23:0] fifo_out_data;

	// Command decode, only while selected.
	wire sel_wr = peripheral_select_strobe && cmd_wr;
	wire sel_rd = peripheral_select_strobe && cmd_rd;
	wire do_start = sel_wr && (cmd_addr == ihpc_pkg::CMD_START);
	wire do_dir = sel_wr && (cmd_addr == ihpc_pkg::CMD_DIR);
	wire do_abort = sel_wr && (cmd_addr == ihpc_pkg::CMD_ABORT);

	// Edges of the reference crystal and the print strobe.
	wire ref_tick = pulse_reference_crystal && !ref_d_r;
	wire pts_rise = print_timing_strobe && !pts_d_r;
	wire lines_idle = !busy_odd && !busy_even;

	// A column leaves the FIFO only on a strobe with both lines at rest.
	wire col_pop = pts_rise && lines_idle && fifo_out_valid;
	wire take_byte = transfer_request && dma_ack;
	wire col_done = take_byte && (byte_idx_r == 2'(ihpc_pkg::BYTES_PER_COL-1));
	wire [23:0] col_word = {dma_data, asm_r};
	wire job_busy = (cols_left_r != ihpc_pkg::RST_BYTE) || !lines_idle;

	// Reorder: the lagging line takes last column's bits, chosen by direction.
	wire [23:0] lead_mask = dir_r ? ihpc_pkg::EVEN_MASK : ihpc_pkg::ODD_MASK;
	wire [23:0] col_new = (fifo_out_data & lead_mask) |
		(even_hold_r & ~lead_mask);

	// Request is dropped when the FIFO is full, so DMA stalls on back-pressure.
	wire req_nxt = (bytes_left_r != 10'h000) && fifo_in_ready &&
		!do_abort && !(take_byte && bytes_left_r == 10'h001);

	ihpc_fifo #(
		.WIDTH(ihpc_pkg::NOZZLES),
		.DEPTH(ihpc_pkg::FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.flush(do_abort),
		.in_valid(col_done),
		.in_ready(fifo_in_ready),
		.in_data(col_word),
		.out_valid(fifo_out_valid),
		.out_ready(col_pop),
		.out_data(fifo_out_data)
	);

	ihpc_line_seq u_odd (
		.core_clk(core_clk),
		.rst(rst),
		.trigger(col_pop),
		.ref_tick(ref_tick),
		.fire_r(fire_odd),
		.refill_r(refill_pulse_first_line),
		.busy(busy_odd)
	);

	ihpc_line_seq u_even (
		.core_clk(core_clk),
		.rst(rst),
		.trigger(col_pop),
		.ref_tick(ref_tick),
		.fire_r(fire_even),
		.refill_r(refill_pulse_second_line),
		.busy(busy_even)
	);

	// Edge detector flops for the two timing inputs.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ref_d_r <= 1'b0;
			pts_d_r <= 1'b0;
		end else begin
			ref_d_r <= pulse_reference_crystal;
			pts_d_r <= print_timing_strobe;
		end
	end

	// Job counters; a start while busy reloads them, abort clears them.
	always_ff @(posedge core_clk) begin
		if (rst || do_abort) begin
			cols_left_r <= ihpc_pkg::RST_BYTE;
			bytes_left_r <= 10'h000;
			byte_idx_r <= 2'b00;
			transfer_request <= 1'b0;
		end else begin
			transfer_request <= req_nxt && !do_start;
			if (do_start) begin
				cols_left_r <= cmd_wdata;
				bytes_left_r <= 10'(cmd_wdata) * 10'(ihpc_pkg::BYTES_PER_COL);
				byte_idx_r <= 2'b00;
			end else begin
				if (col_pop) begin
					cols_left_r <= cols_left_r - 8'h01;
				end
				if (take_byte) begin
					bytes_left_r <= bytes_left_r - 10'h001;
					byte_idx_r <= col_done ? 2'b00 : byte_idx_r + 2'b01;
				end
			end
		end
	end

	// Byte assembly, low byte is the first nozzles of the column.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			asm_r <= 16'h0000;
		end else if (take_byte && byte_idx_r == 2'b00) begin
			asm_r[7:0] <= dma_data;
		end else if (take_byte && byte_idx_r == 2'b01) begin
			asm_r[15:8] <= dma_data;
		end
	end

	// Direction register and the column latches.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dir_r <= 1'b0;
			col_latch_r <= ihpc_pkg::RST_COL;
			even_hold_r <= ihpc_pkg::RST_COL;
		end else begin
			if (do_dir) begin
				dir_r <= cmd_wdata[0];
			end
			if (col_pop) begin
				col_latch_r <= col_new;
				even_hold_r <= fifo_out_data;
			end
		end
	end

	// Fire outputs follow each line's discharge window, masked by the data.
	wire [23:0] odd_en = fire_odd ? ihpc_pkg::ODD_MASK : ihpc_pkg::RST_COL;
	wire [23:0] even_en = fire_even ? ihpc_pkg::EVEN_MASK : ihpc_pkg::RST_COL;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			nozzle_fire_output <= ihpc_pkg::RST_COL;
		end else begin
			nozzle_fire_output <= col_latch_r & (odd_en | even_en);
		end
	end

	// Read data is registered; unselected or unknown reads return zero.
	wire [7:0] status = {4'h0, transfer_request, dir_r, !fifo_out_valid,
		job_busy};
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cmd_rdata <= ihpc_pkg::RST_BYTE;
		end else if (sel_rd && cmd_addr == ihpc_pkg::RD_STATUS) begin
			cmd_rdata <= status;
		end else if (sel_rd && cmd_addr == ihpc_pkg::RD_COLS) begin
			cmd_rdata <= cols_left_r;
		end else begin
			cmd_rdata <= ihpc_pkg::RST_BYTE;
		end
	end
endmodule

`default_nettype wire

// ==== verif/ihpc_head_ctrl_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none

// Watches the command port, the strobe and the pulse outputs of the top.
module ihpc_chk (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic peripheral_select_strobe,
	input wire logic [3:0] cmd_addr,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic [7:0] cmd_rdata,
	input wire logic transfer_request,
	input wire logic print_timing_strobe,
	input wire logic pulse_reference_crystal,
	input wire logic [23:0] nozzle_fire_output,
	input wire logic refill_pulse_first_line,
	input wire logic refill_pulse_second_line
);
	logic cr_q;
	logic [1:0] st_q;
	logic [7:0] cnt_r;
	wire [23:0] odd_f = nozzle_fire_output & ihpc_pkg::ODD_MASK;
	wire [23:0] even_f = nozzle_fire_output & ihpc_pkg::EVEN_MASK;
	wire [1:0] st = {|odd_f, refill_pulse_first_line};

	// Raw crystal edges are counted, so a wrong tick divider shows up.
	always_ff @(posedge core_clk) begin
		cr_q <= pulse_reference_crystal;
		st_q <= st;
		if (rst || st != st_q)
			cnt_r <= 8'h00;
		else if (pulse_reference_crystal && !cr_q)
			cnt_r <= cnt_r + 8'h01;
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_rd_idle;
		!(peripheral_select_strobe && cmd_rd) |=> cmd_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data without a selected read");
	property p_rd_unmapped;
		peripheral_select_strobe && cmd_rd && cmd_addr > 4'h1
			|=> cmd_rdata == 8'h00;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped)
		else $error("unmapped read returned data");
	property p_abort;
		peripheral_select_strobe && cmd_wr
			&& cmd_addr == ihpc_pkg::CMD_ABORT |=> !transfer_request [*2];
	endproperty
	a_abort: assert property (p_abort)
		else $error("transfer request survived abort");
	// The strobe window of three samples covers either edge-detect phase.
	property p_fire_start;
		$rose(|odd_f) |-> $past(print_timing_strobe)
			&& !$past(print_timing_strobe, 3);
	endproperty
	a_fire_start: assert property (p_fire_start)
		else $error("fire began without a strobe");
	property p_col_hold;
		|odd_f |=> odd_f == 24'h000000 || $stable(odd_f);
	endproperty
	a_col_hold: assert property (p_col_hold)
		else $error("fire pattern changed mid pulse");
	property p_dis_len;
		$fell(|odd_f) |-> cnt_r inside {[8'h7B:8'h7D]};
	endproperty
	a_dis_len: assert property (p_dis_len)
		else $error("discharge length wrong");
	property p_gap_len;
		$rose(refill_pulse_first_line) |-> cnt_r inside {[8'h0F:8'h11]};
	endproperty
	a_gap_len: assert property (p_gap_len)
		else $error("idle gap length wrong");
	property p_chg_len;
		$fell(refill_pulse_first_line) |-> cnt_r inside {[8'h5E:8'h60]};
	endproperty
	a_chg_len: assert property (p_chg_len)
		else $error("refill length wrong");
	property p_overlap_a;
		!(|odd_f && refill_pulse_first_line);
	endproperty
	a_overlap_a: assert property (p_overlap_a)
		else $error("first line fire and refill overlap");
	property p_overlap_b;
		!(|even_f && refill_pulse_second_line);
	endproperty
	a_overlap_b: assert property (p_overlap_b)
		else $error("second line fire and refill overlap");

	c_start: cover property (cmd_wr && cmd_addr == ihpc_pkg::CMD_START);
	c_fire: cover property ($rose(|odd_f));
	c_refill: cover property ($fell(refill_pulse_first_line));
endmodule

`default_nettype wire

// ==== verif/ihpc_head_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// Piezo drivers: a nozzle fires only if its element holds charge; every element starts charged.
module ihpc_head_model (
	input wire logic core_clk,
	input wire logic [23:0] nozzle_fire_output,
	input wire logic refill_pulse_first_line,
	input wire logic refill_pulse_second_line,
	output int shots
);
	logic [23:0] chg_r = 24'hFFFFFF;
	logic [23:0] fire_q = 24'h000000;
	logic ra_q = 1'b0, rb_q = 1'b0;

	// A shot spends the charge; a refill edge restores its own line.
	initial shots = 0;
	always @(posedge core_clk) begin
		for (int i = 0; i < 24; i++)
			if (nozzle_fire_output[i] && !fire_q[i] && chg_r[i]) begin
				shots++;
				chg_r[i] = 1'b0;
			end
		if (refill_pulse_first_line && !ra_q)
			chg_r = chg_r | ihpc_pkg::ODD_MASK;
		if (refill_pulse_second_line && !rb_q)
			chg_r = chg_r | ihpc_pkg::EVEN_MASK;
		fire_q = nozzle_fire_output;
		ra_q = refill_pulse_first_line;
		rb_q = refill_pulse_second_line;
	end
endmodule

`default_nettype wire

// ==== verif/test_inkjet_head_pulse_controller.sv ====
`timescale 1ns/10ps
`default_nettype none

module test_inkjet_head_pulse_controller;
	typedef struct {
		logic ws;
		logic [3:0] wa;
		logic [7:0] wd;
		logic rs;
		logic [3:0] ra;
		logic [7:0] ex;
	} ihpc_row_s;
	logic core_clk = 1'b0, rst = 1'b1, sel = 1'b0, cmd_wr = 1'b0;
	logic cmd_rd = 1'b0, dma_ack = 1'b0, strobe = 1'b0, xtal = 1'b0;
	logic dma_on = 1'b0, ref_a, ref_b, xfer;
	logic [3:0] cmd_addr = 4'h0;
	logic [7:0] cmd_wdata = 8'h00, dma_data = 8'h00, cmd_rdata, v;
	logic [23:0] fire;
	logic [7:0] img [0:63];
	int n_errors = 0, checked = 0, k = 0, nb = 0, shots, xc = 0;
	ihpc_row_s rows [7] = '{'{1, 4'h1, 8'h01, 1, 4'h0, 8'h06},
		'{0, 4'h1, 8'h00, 1, 4'h0, 8'h06}, '{1, 4'h1, 8'h00, 1, 4'h0, 8'h02},
		'{0, 4'h0, 8'h05, 1, 4'h0, 8'h02}, '{1, 4'h7, 8'hFF, 1, 4'h0, 8'h02},
		'{1, 4'h7, 8'hFF, 0, 4'h0, 8'h00}, '{1, 4'h7, 8'hFF, 1, 4'h9, 8'h00}};

	ihpc_head_ctrl dut (.core_clk(core_clk), .rst(rst),
		.peripheral_select_strobe(sel), .cmd_addr(cmd_addr),
		.cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata),
		.cmd_rdata(cmd_rdata), .transfer_request(xfer), .dma_ack(dma_ack),
		.dma_data(dma_data), .print_timing_strobe(strobe),
		.pulse_reference_crystal(xtal), .nozzle_fire_output(fire),
		.refill_pulse_first_line(ref_a), .refill_pulse_second_line(ref_b));
	ihpc_head_model u_head (.core_clk(core_clk), .nozzle_fire_output(fire),
		.refill_pulse_first_line(ref_a), .refill_pulse_second_line(ref_b),
		.shots(shots));

	// Clock, and a crystal eight cycles long to keep pulse runs short.
	always #2 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		xc <= (xc == 7) ? 0 : xc + 1;
		xtal <= xc < 4;
	end

	// DMA side holds each byte until taken; idle data toggles, not stale.
	always @(posedge core_clk) begin
		if (dma_ack && xfer)
			k = k + 1;
		dma_ack <= dma_on && k < nb;
		dma_data <= (dma_on && k < nb) ? img[k] : ~dma_data;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic wr(input logic s, input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		sel <= s;
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_wr <= 1'b1;
		@(posedge core_clk);
		cmd_wr <= 1'b0;
		sel <= 1'b0;
	endtask

	task automatic rd(input logic s, input logic [3:0] a);
		@(posedge core_clk);
		sel <= s;
		cmd_addr <= a;
		cmd_rd <= 1'b1;
		@(posedge core_clk);
		cmd_rd <= 1'b0;
		sel <= 1'b0;
		#1 v = cmd_rdata;
	endtask

	// The strobe is the motor unit's; it stays high a few cycles per column.
	task automatic pulse();
		@(posedge core_clk);
		strobe <= 1'b1;
		repeat (3) @(posedge core_clk);
		strobe <= 1'b0;
	endtask

	function automatic logic probe(input int w);
		return w == 0 ? |fire : w == 1 ? ref_a : w == 2 ? ref_b :
			w == 3 ? xfer : k == nb;
	endfunction

	task automatic wait_on(input int w, input logic lv);
		int i;
		#1;
		for (i = 0; i < 3000 && probe(w) !== lv; i++)
			@(posedge core_clk) #1;
		if (i == 3000) begin
			n_errors++;
			tally_and_finish();
		end
	endtask

	// Table rows first, then a two-column job, a FIFO fill and an abort.
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		#1 chk({fire, ref_a, ref_b, xfer, cmd_rdata[4:0]}, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].ws, rows[i].wa, rows[i].wd);
			rd(rows[i].rs, rows[i].ra);
			chk(v, rows[i].ex);
		end
		{img[2], img[1], img[0]} = 24'hC35A81;
		{img[5], img[4], img[3]} = 24'h0FF03C;
		nb = 6;
		dma_on = 1'b1;
		wr(1'b1, ihpc_pkg::CMD_START, 8'h02);
		wait_on(4, 1'b1);
		pulse();
		wait_on(0, 1'b1);
		chk(fire, 24'h415001);
		pulse();
		wait_on(1, 1'b1);
		chk(ref_b, 1'b1);
		rd(1'b1, ihpc_pkg::RD_COLS);
		chk(v, 8'h01);
		wait_on(1, 1'b0);
		wr(1'b1, ihpc_pkg::CMD_DIR, 8'h01);
		pulse();
		wait_on(0, 1'b1);
		chk(fire, 24'h4BF029);
		wait_on(1, 1'b1);
		wait_on(1, 1'b0);
		pulse();
		repeat (40) @(posedge core_clk);
		chk(fire, 24'h000000);
		chk(shots, 16);
		for (int i = 0; i < 64; i++)
			img[i] = 8'(i);
		k = 0;
		nb = 60;
		wr(1'b1, ihpc_pkg::CMD_START, 8'h14);
		wait_on(3, 1'b1);
		wait_on(3, 1'b0);
		// The registered request drops one byte late on a full FIFO.
		chk(k, 3 * ihpc_pkg::FIFO_DEPTH + 1);
		rd(1'b1, ihpc_pkg::RD_STATUS);
		chk({v[ihpc_pkg::ST_DMA_REQ], v[ihpc_pkg::ST_FIFO_EMPTY]}, 0);
		wr(1'b1, ihpc_pkg::CMD_ABORT, 8'h00);
		rd(1'b1, ihpc_pkg::RD_STATUS);
		chk({v[ihpc_pkg::ST_DMA_REQ], v[ihpc_pkg::ST_FIFO_EMPTY]}, 1);
		tally_and_finish();
	end
endmodule

bind ihpc_head_ctrl ihpc_chk u_chk (.core_clk(core_clk), .rst(rst),
	.peripheral_select_strobe(peripheral_select_strobe),
	.cmd_addr(cmd_addr), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
	.cmd_rdata(cmd_rdata), .transfer_request(transfer_request),
	.print_timing_strobe(print_timing_strobe),
	.pulse_reference_crystal(pulse_reference_crystal),
	.nozzle_fire_output(nozzle_fire_output),
	.refill_pulse_first_line(refill_pulse_first_line),
	.refill_pulse_second_line(refill_pulse_second_line));

`default_nettype wire
